// ==== src/ebp_top.sv ====
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module ebp_top
  import ebp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic out_a,
  output logic out_b,
  output logic out_c,
  output logic out_d
);

  // ************************************************************
  // Software registers
  // ************************************************************
  logic [7:0] module_control_reg_r;
  logic [7:0] duty_upper_bits_reg_r;
  logic [7:0] duty_shadow_reg_r;
  logic [1:0] duty_shadow_lo_r;
  logic [7:0] period_reg_r [2];
  logic [7:0] tctl_r [2];
  logic [6:0] deadband_delay_reg_r;
  logic timer_select_reg_r;
  logic flag_r;

  logic [1:0] output_config_field;
  logic [3:0] mode_polarity_field;
  logic direction_bit;
  assign output_config_field = module_control_reg_r[7:6];
  assign mode_polarity_field = module_control_reg_r[3:0];
  assign direction_bit = module_control_reg_r[7];

  // ************************************************************
  // Time bases
  // ************************************************************
  logic [7:0] period_timer_r [2];
  logic [1:0] q_r [2];
  logic [3:0] pre_r [2];
  logic [3:0] post_r [2];
  logic tick [2];
  logic match [2];
  logic postev [2];
  logic [1:0] ext [2];
  logic [3:0] pre_max [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_tmr
      always_comb
      begin
        unique case (tctl_r[gi][1:0])
          EBP_PS1: pre_max[gi] = 4'h0;
          EBP_PS4: pre_max[gi] = EBP_PRE_MAX4;
          default: pre_max[gi] = EBP_PRE_MAX16;
        endcase
      end

      always_comb
      begin
        unique case (tctl_r[gi][1:0])
          EBP_PS1: ext[gi] = q_r[gi];
          EBP_PS4: ext[gi] = pre_r[gi][1:0];
          default: ext[gi] = pre_r[gi][3:2];
        endcase
      end

      // one step every 4 clocks times prescale
      assign tick[gi] = tctl_r[gi][EBP_T_ON] && (q_r[gi] == EBP_Q_LAST)
                        && (pre_r[gi] == pre_max[gi]);
      assign match[gi] = period_timer_r[gi] == period_reg_r[gi];

      // Quadrature and prescale counters
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          q_r[gi] <= 2'h0;
          pre_r[gi] <= 4'h0;
        end
        else if (tctl_r[gi][EBP_T_ON])
        begin
          q_r[gi] <= q_r[gi] + 2'h1;
          if (q_r[gi] == EBP_Q_LAST)
            pre_r[gi] <= (pre_r[gi] == pre_max[gi]) ? 4'h0
                         : pre_r[gi] + 4'h1;
        end
      end

      // timer clears on the step after a period match
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          period_timer_r[gi] <= EBP_RST8;
        else if (tick[gi])
          period_timer_r[gi] <= match[gi] ? EBP_RST8
                                : period_timer_r[gi] + 8'h01;
      end

      // postscaler only paces the flag, not the period
      assign postev[gi] = tick[gi] && match[gi]
                          && (post_r[gi] == tctl_r[gi][6:EBP_T_POST_LO]);
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          post_r[gi] <= 4'h0;
        else if (tick[gi] && match[gi])
          post_r[gi] <= postev[gi] ? 4'h0 : post_r[gi] + 4'h1;
      end
    end
  endgenerate

  logic sel_tick;
  logic sel_match;
  logic sel_post;
  logic [9:0] sel_ext_tmr;
  logic period_start;
  assign sel_tick = tick[timer_select_reg_r];
  assign sel_match = match[timer_select_reg_r];
  assign sel_post = postev[timer_select_reg_r];
  assign sel_ext_tmr = {period_timer_r[timer_select_reg_r],
                        ext[timer_select_reg_r]};
  assign period_start = sel_tick && sel_match;

  // ************************************************************
  // Register writes
  // ************************************************************
  // Writable control registers; shadow duty is not among them
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      module_control_reg_r <= EBP_RST8;
      duty_upper_bits_reg_r <= EBP_RST8;
      period_reg_r[0] <= EBP_RST8;
      period_reg_r[1] <= EBP_RST8;
      tctl_r[0] <= EBP_RST8;
      tctl_r[1] <= EBP_RST8;
      deadband_delay_reg_r <= 7'h00;
      timer_select_reg_r <= 1'b0;
    end
    else if (wr)
    begin
      // duty bits accept writes at any time
      unique case (addr)
        EBP_A_CTRL: module_control_reg_r <= wdata;
        EBP_A_DUTY: duty_upper_bits_reg_r <= wdata;
        EBP_A_PER0: period_reg_r[0] <= wdata;
        EBP_A_TCTL0: tctl_r[0] <= {1'b0, wdata[6:0]};
        EBP_A_PER1: period_reg_r[1] <= wdata;
        EBP_A_TCTL1: tctl_r[1] <= {1'b0, wdata[6:0]};
        EBP_A_DEADBAND: deadband_delay_reg_r <= wdata[6:0];
        EBP_A_TSEL: timer_select_reg_r <= wdata[0];
        default: ;
      endcase
    end
  end

  // Period flag: set wins over a write-one clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      flag_r <= 1'b0;
    else if (sel_post)
      flag_r <= 1'b1;
    else if (wr && addr == EBP_A_STATUS && wdata[0])
      flag_r <= 1'b0;
  end

  // ************************************************************
  // Buffered copies loaded at the period boundary; dead band also at a duty hit
  // ************************************************************
  logic [1:0] cfg_act_r;
  logic [3:0] mode_act_r;
  logic [6:0] db_act_r;
  logic [9:0] duty_act;
  logic duty_zero;
  logic duty_hit;
  // ten-bit duty from the shadow copies of upper register and control bits 5:4
  assign duty_act = {duty_shadow_reg_r, duty_shadow_lo_r};
  assign duty_zero = {duty_upper_bits_reg_r,
                      module_control_reg_r[5:4]} == 10'h000;
  // a hit masks the output in the very clock it matches
  assign duty_hit = duty_act == sel_ext_tmr;

  // configuration and mode change only at period start
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_act_r <= EBP_CFG_SINGLE;
      mode_act_r <= 4'h0;
    end
    else if (period_start)
    begin
      cfg_act_r <= output_config_field;
      mode_act_r <= mode_polarity_field;
    end
  end

  // shadow duty loads only at a period match
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      duty_shadow_reg_r <= EBP_RST8;
      duty_shadow_lo_r <= 2'h0;
    end
    else if (period_start)
    begin
      duty_shadow_reg_r <= duty_upper_bits_reg_r;
      duty_shadow_lo_r <= module_control_reg_r[5:4];
    end
  end

  // dead band loads at duty or period boundary
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      db_act_r <= 7'h00;
    else if (period_start || duty_hit)
      db_act_r <= deadband_delay_reg_r;
  end

  // ************************************************************
  // Modulator
  // ************************************************************
  logic pwm_r;
  // set at period start unless 0%; no hit means no clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pwm_r <= 1'b0;
    else if (period_start)
      pwm_r <= !duty_zero;
    else if (duty_hit)
      pwm_r <= 1'b0;
  end

  // swap window one timer step before the period ends
  logic swap_r;
  logic swap_req;
  assign swap_req = cfg_act_r[0] && output_config_field[0]
                    && (direction_bit != cfg_act_r[1]);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      swap_r <= 1'b0;
    else if (period_start)
      swap_r <= 1'b0;
    else if (sel_tick && swap_req
             && period_timer_r[timer_select_reg_r] + 8'h01
                == period_reg_r[timer_select_reg_r])
      swap_r <= 1'b1;
  end

  // ************************************************************
  // Half-bridge dead band
  // ************************************************************
  logic [1:0] hb_raw;
  logic [1:0] hb_act;
  logic [8:0] db_cnt_r [2];
  logic [8:0] db_target;
  // A is PWM, B its complement
  assign hb_raw = {!(pwm_r && !duty_hit), pwm_r && !duty_hit};
  assign db_target = {db_act_r, 2'h0};

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_db
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          db_cnt_r[gi] <= 9'h000;
        else if (!hb_raw[gi])
          db_cnt_r[gi] <= 9'h000;
        else if (db_cnt_r[gi] != db_target)
          db_cnt_r[gi] <= db_cnt_r[gi] + 9'h001;
      end
      assign hb_act[gi] = hb_raw[gi] && (db_cnt_r[gi] == db_target);
    end
  endgenerate

  // ************************************************************
  // Output steering
  // ************************************************************
  logic [3:0] act;
  logic new_rev;
  assign new_rev = swap_r ? direction_bit : cfg_act_r[1];
  always_comb
  begin
    act = 4'h0;
    if (cfg_act_r == EBP_CFG_SINGLE)
      act[0] = pwm_r && !duty_hit;
    else if (cfg_act_r == EBP_CFG_HALF)
      act[1:0] = hb_act;
    else
    begin
      // modulated off and unmodulated swapped in the window
      if (new_rev)
      begin
        act[2] = 1'b1;
        act[1] = pwm_r && !duty_hit && !swap_r;
      end
      else
      begin
        act[0] = 1'b1;
        act[3] = pwm_r && !duty_hit && !swap_r;
      end
    end
  end

  // enhanced modes lag by one instruction cycle
  logic [3:0] lag_r [EBP_LAG];
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < EBP_LAG; i++)
        lag_r[i] <= 4'h0;
    end
    else
    begin
      lag_r[0] <= act;
      for (int i = 1; i < EBP_LAG; i++)
        lag_r[i] <= lag_r[i-1];
    end
  end

  logic [3:0] act_out;
  logic pwm_on;
  logic inv_ac;
  logic inv_bd;
  assign act_out = (cfg_act_r == EBP_CFG_SINGLE) ? act
                   : lag_r[EBP_LAG-1];
  assign pwm_on = mode_act_r[3:2] == EBP_PWM_MODE;
  assign inv_ac = pwm_on && mode_act_r[1];
  assign inv_bd = pwm_on && mode_act_r[0];

  // pair polarity; outputs low outside PWM mode
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
      out_d <= 1'b0;
    end
    else
    begin
      out_a <= (pwm_on && act_out[0]) ^ inv_ac;
      out_b <= (pwm_on && act_out[1]) ^ inv_bd;
      out_c <= (pwm_on && act_out[2]) ^ inv_ac;
      out_d <= (pwm_on && act_out[3]) ^ inv_bd;
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (addr)
      EBP_A_CTRL: rd_mux = module_control_reg_r;
      EBP_A_DUTY: rd_mux = duty_upper_bits_reg_r;
      EBP_A_SHADOW: rd_mux = duty_shadow_reg_r;
      EBP_A_PER0: rd_mux = period_reg_r[0];
      EBP_A_TCTL0: rd_mux = tctl_r[0];
      EBP_A_PER1: rd_mux = period_reg_r[1];
      EBP_A_TCTL1: rd_mux = tctl_r[1];
      EBP_A_DEADBAND: rd_mux = {1'b0, deadband_delay_reg_r};
      EBP_A_TSEL: rd_mux = {7'h00, timer_select_reg_r};
      EBP_A_TMR0: rd_mux = period_timer_r[0];
      EBP_A_TMR1: rd_mux = period_timer_r[1];
      EBP_A_STATUS: rd_mux = {3'h0, cfg_act_r, cfg_act_r[1], swap_r, flag_r};
      default: rd_mux = EBP_RST8;
    endcase
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= EBP_RST8;
    else if (rd)
      rdata <= rd_mux;
    else
      rdata <= EBP_RST8;
  end

endmodule : ebp_top

// ==== src/ebp_pkg.sv ====
package ebp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] EBP_A_CTRL = 4'h0;
  localparam logic [3:0] EBP_A_DUTY = 4'h1;
  localparam logic [3:0] EBP_A_SHADOW = 4'h2;
  localparam logic [3:0] EBP_A_PER0 = 4'h3;
  localparam logic [3:0] EBP_A_TCTL0 = 4'h4;
  localparam logic [3:0] EBP_A_PER1 = 4'h5;
  localparam logic [3:0] EBP_A_TCTL1 = 4'h6;
  localparam logic [3:0] EBP_A_DEADBAND = 4'h7;
  localparam logic [3:0] EBP_A_TSEL = 4'h8;
  localparam logic [3:0] EBP_A_TMR0 = 4'h9;
  localparam logic [3:0] EBP_A_TMR1 = 4'ha;
  localparam logic [3:0] EBP_A_STATUS = 4'hb;

  // ************************************************************
  // Field values
  // ************************************************************
  localparam logic [7:0] EBP_RST8 = 8'h00;
  localparam logic [1:0] EBP_CFG_SINGLE = 2'h0;
  localparam logic [1:0] EBP_CFG_HALF = 2'h2;
  localparam logic [1:0] EBP_PWM_MODE = 2'h3;
  localparam logic [1:0] EBP_PS1 = 2'h0;
  localparam logic [1:0] EBP_PS4 = 2'h1;
  localparam logic [3:0] EBP_PRE_MAX4 = 4'h3;
  localparam logic [3:0] EBP_PRE_MAX16 = 4'hf;
  localparam logic [1:0] EBP_Q_LAST = 2'h3;
  localparam int EBP_TOSC_PER_TCY = 4;
  localparam int EBP_LAG_TCY = 1;
  localparam int EBP_LAG = EBP_LAG_TCY * EBP_TOSC_PER_TCY;

  // Timer control bits
  localparam int EBP_T_ON = 2;
  localparam int EBP_T_POST_LO = 3;

endpackage : ebp_pkg

// ==== sim/ebp_assertions.sv ====
`timescale 1ns/1ps
module ebp_assertions
  import ebp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_c,
  input wire logic out_d
);
  // ************************************************************
  // Settled view of the written setup
  // ************************************************************
  logic [7:0] ctl_r;
  logic [7:0] dty_r;
  logic [7:0] per_r;
  logic [6:0] db_r;
  logic [8:0] quiet_r;
  logic [3:0] cp;

  // Copies of written values and quiet time since last write
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_r <= 8'h00;
      dty_r <= 8'h00;
      per_r <= 8'h00;
      db_r <= 7'h00;
      quiet_r <= 9'h000;
    end
    else if (wr)
    begin
      quiet_r <= 9'h000;
      if (addr == EBP_A_CTRL)
        ctl_r <= wdata;
      if (addr == EBP_A_DUTY)
        dty_r <= wdata;
      if (addr == EBP_A_PER0)
        per_r <= wdata;
      if (addr == EBP_A_DEADBAND)
        db_r <= wdata[6:0];
    end
    else if (quiet_r != 9'h1ff)
      quiet_r <= quiet_r + 9'h001;
  end

  // Output arrangement and polarity
  assign cp = {ctl_r[7:6], ctl_r[1:0]};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_run(logic [3:0] c);
    quiet_r > 9'h190 && ctl_r[3:2] == 2'h3 && cp == c;
  endsequence

  property p_rst_out;
    $rose(resetn) |-> {out_a, out_b, out_c, out_d} == 4'h0;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("output active after reset");
  property p_idle;
    quiet_r > 9'h190 && ctl_r[3:2] != 2'h3
      |-> {out_a, out_b, out_c, out_d} == 4'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("output active outside pwm mode");
  property p_single;
    s_run(4'h0) |-> {out_b, out_c, out_d} == 3'h0;
  endproperty
  a_single: assert property (p_single)
    else $error("unused output active in single mode");
  property p_fwd;
    s_run(4'h4) |-> {out_a, out_b, out_c} == 3'h4;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward bridge levels wrong");
  property p_rev;
    s_run(4'hc) |-> {out_a, out_c, out_d} == 3'h2;
  endproperty
  a_rev: assert property (p_rev)
    else $error("reverse bridge levels wrong");
  property p_pol;
    s_run(4'h7) |-> {out_a, out_b, out_c} == 3'h3;
  endproperty
  a_pol: assert property (p_pol)
    else $error("active low levels wrong");
  property p_over;
    s_run(4'h0) ##0 ({dty_r, ctl_r[5:4]} > {per_r, 2'h3}) |-> out_a;
  endproperty
  a_over: assert property (p_over)
    else $error("output cleared with duty above period");
  property p_dead;
    s_run(4'h8) ##0 (db_r != 7'h00 && $rose(out_a))
      |-> !$past(out_b) && !$past(out_b, 3);
  endproperty
  a_dead: assert property (p_dead)
    else $error("no dead band before output a");
endmodule : ebp_assertions

bind ebp_top ebp_assertions ebp_assertions_i (.core_clk(core_clk),
  .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .out_a(out_a), .out_b(out_b), .out_c(out_c),
  .out_d(out_d));

// ==== sim/ebp_bridge_drv.sv ====
`timescale 1ns/1ps
module ebp_bridge_drv
(
  input wire logic core_clk,
  input wire logic clr,
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_c,
  input wire logic out_d,
  output logic [15:0] cnt_a,
  output logic [15:0] cnt_b,
  output logic [15:0] cnt_c,
  output logic [15:0] cnt_d
);
  // ************************************************************
  // Switch drivers: clocks each gate input is driven high
  // ************************************************************
  // gate inputs see the outputs as driven pins
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      cnt_a <= 16'h0;
      cnt_b <= 16'h0;
      cnt_c <= 16'h0;
      cnt_d <= 16'h0;
    end
    else
    begin
      cnt_a <= cnt_a + 16'(out_a);
      cnt_b <= cnt_b + 16'(out_b);
      cnt_c <= cnt_c + 16'(out_c);
      cnt_d <= cnt_d + 16'(out_d);
    end
  end
endmodule : ebp_bridge_drv

// ==== sim/ebp_top_tb.sv ====
`timescale 1ns/1ps
module ebp_top_tb;
  import ebp_pkg::*;
  logic core_clk, resetn, wr, rd, clr;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic out_a, out_b, out_c, out_d;
  logic [15:0] cnt_a, cnt_b, cnt_c, cnt_d;
  int failures, num_checks;

  ebp_top ebp_top_i (.core_clk(core_clk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));
  ebp_bridge_drv ebp_bridge_drv_i (.core_clk(core_clk), .clr(clr),
    .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
    .cnt_a(cnt_a), .cnt_b(cnt_b), .cnt_c(cnt_c), .cnt_d(cnt_d));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bw(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask : bw

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk);
    rd <= 1'h0;
    #1;
    chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask : rchk

  // Settle, then count active clocks over n cycles
  task automatic meas(input int n, input logic [15:0] ea, eb, ec, ed);
    repeat (600) @(posedge core_clk);
    clr <= 1'h1;
    @(posedge core_clk);
    clr <= 1'h0;
    repeat (n) @(posedge core_clk);
    #1;
    chk("out_a", cnt_a, ea);
    chk("out_b", cnt_b, eb);
    chk("out_c", cnt_c, ec);
    chk("out_d", cnt_d, ed);
  endtask : meas

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    for (int i = 0; i < 16; i++)
      rchk(4'(i), 8'h00);
    meas(160, 16'h0, 16'h0, 16'h0, 16'h0);
    $display("reset done");
  endtask : t_reset

  task automatic t_regs();
    bw(EBP_A_DUTY, 8'h5a);
    rchk(EBP_A_DUTY, 8'h5a);
    bw(EBP_A_SHADOW, 8'hff);
    rchk(EBP_A_SHADOW, 8'h00);
    $display("registers done");
  endtask : t_regs

  task automatic t_single();
    bw(EBP_A_PER0, 8'h03);
    bw(EBP_A_DUTY, 8'h01);
    bw(EBP_A_CTRL, 8'h2c);
    bw(EBP_A_TCTL0, 8'h04);
    meas(160, 16'h3c, 16'h0, 16'h0, 16'h0);
    rchk(EBP_A_SHADOW, 8'h01);
    $display("single done");
  endtask : t_single

  task automatic t_presc();
    int s;
    for (int i = 0; i < 3; i++)
    begin
      s = 1 << (2 * i);
      bw(EBP_A_TCTL0, 8'h7c | 8'(i));
      meas(160 * s, 16'(60 * s), 16'h0, 16'h0, 16'h0);
    end
    bw(EBP_A_TCTL0, 8'h04);
    $display("prescale done");
  endtask : t_presc

  task automatic t_edges();
    bw(EBP_A_DUTY, 8'h00);
    bw(EBP_A_CTRL, 8'h0c);
    meas(160, 16'h0, 16'h0, 16'h0, 16'h0);
    bw(EBP_A_DUTY, 8'h10);
    meas(160, 16'ha0, 16'h0, 16'h0, 16'h0);
    $display("duty limits done");
  endtask : t_edges

  task automatic t_half();
    bw(EBP_A_DUTY, 8'h01);
    bw(EBP_A_DEADBAND, 8'h01);
    bw(EBP_A_CTRL, 8'hac);
    meas(160, 16'h14, 16'h3c, 16'h0, 16'h0);
    bw(EBP_A_DEADBAND, 8'h02);
    meas(160, 16'h0, 16'h14, 16'h0, 16'h0);
    $display("half bridge done");
  endtask : t_half

  task automatic t_full();
    bw(EBP_A_CTRL, 8'h6c);
    meas(160, 16'ha0, 16'h0, 16'h0, 16'h3c);
    bw(EBP_A_CTRL, 8'hec);
    meas(160, 16'h0, 16'h3c, 16'ha0, 16'h0);
    rchk(EBP_A_STATUS, 8'h1d);
    bw(EBP_A_CTRL, 8'h6f);
    meas(160, 16'h0, 16'ha0, 16'ha0, 16'h64);
    $display("full bridge done");
  endtask : t_full

  task automatic t_timer1();
    bw(EBP_A_CTRL, 8'h2c);
    bw(EBP_A_PER1, 8'h07);
    bw(EBP_A_TCTL1, 8'h04);
    bw(EBP_A_TSEL, 8'h01);
    meas(320, 16'h3c, 16'h0, 16'h0, 16'h0);
    $display("timer select done");
  endtask : t_timer1

  // Clock at 25 ns
  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Main sequence
  initial
  begin
    failures = 0;
    num_checks = 0;
    resetn = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    clr = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset();
    t_regs();
    t_single();
    t_presc();
    t_edges();
    t_half();
    t_full();
    t_timer1();
    test_done();
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    test_done();
  end
endmodule : ebp_top_tb
